// ---- verilog/xcvr_regs_pkg.sv ----
package xcvr_regs_pkg;

    // ==========================================================
    // Register map
    // ==========================================================
    localparam int ADDR_W = 6;
    localparam logic [5:0] ADDR_CHANGE = 6'h01;
    localparam logic [5:0] ADDR_STATUS = 6'h02;
    localparam logic [5:0] ADDR_CONFIG = 6'h03;
    localparam logic [7:0] CONFIG_RESET = 8'h40;
    localparam logic [7:0] READ_ZERO = 8'h00;

    // ==========================================================
    // Configuration field positions
    // ==========================================================
    localparam int BIT_REF_FREQ = 6;
    localparam int BIT_BANDWIDTH = 4;
    localparam int BIT_DEJITTER = 3;
    localparam int BIT_AUX_DIS = 2;
    localparam int BIT_AUTO_FLUSH = 1;
    localparam int BIT_MANUAL_FLUSH = 0;

    // ==========================================================
    // Flush timing in transmit parallel clock cycles
    // ==========================================================
    localparam int FLUSH_TICKS = 8;
    localparam int FLUSH_MAX_TICKS = 10;
    localparam int STATUS_W = 5;

    // Field order matches status bits 4 down to 0.
    typedef struct packed {
        logic oscillator_lock_flag;
        logic signal_loss_flag;
        logic recovery_lock_flag;
        logic multiplier_lock_flag;
        logic overflow_flag;
    } status_s;

    typedef struct packed {
        logic ref_freq_select;
        logic multiplier_bandwidth_select;
        logic dejitter_ref_select;
        logic aux_clock_disable;
        logic auto_flush_enable;
        logic manual_flush_bit;
    } config_s;

    typedef enum logic [1:0] {
        FLUSH_IDLE,
        FLUSH_HOLD,
        FLUSH_DRAIN
    } flush_state_e;

endpackage

// ---- verilog/level_sync.sv ----
`timescale 1ns/1ps

module level_sync #(
    parameter int WIDTH = 5
) (
    input wire logic clock_in,
    input wire logic rst_in,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    // ==========================================================
    // Two-stage synchroniser per bit
    // ==========================================================
    generate
        for (genvar i = 0; i < WIDTH; i++)
        begin : g_bit
            logic stage1_r;
            logic stage2_r;
            always_ff @(posedge clock_in or posedge rst_in)
            begin
                if (rst_in)
                begin
                    stage1_r <= 1'b0;
                    stage2_r <= 1'b0;
                end
                else
                begin
                    stage1_r <= async_in[i];
                    stage2_r <= stage1_r;
                end
            end
            assign sync_out[i] = stage2_r;
        end
    endgenerate

endmodule

// ---- verilog/transceiver_status_config_regs.sv ----
// Function
// - Bit 4 shows oscillator lock state.
// - Bit 3 shows present signal loss.
// - Bit 2 shows recovery loop lock.
// - Bit 1 shows multiplier loop lock.
// - Bit 0 shows transmit FIFO overflow.
// - Status read-only, zero after reset.
// - Config bit 6 selects reference frequency.
// - Config bit 4 selects multiplier bandwidth.
// - Config bit 3 selects reference source.
// - Config bit 2 disables auxiliary clock.
// - Config bit 1 enables automatic overflow flush.
// - Flush completes 8-10 cycles after release.
// - Config bit 0 holds FIFO in reset.
// - Oscillator lock detect only when enabled.
// - Status changes latch, cleared on read.
`timescale 1ns/1ps

module transceiver_status_config_regs #(
    parameter int FLUSH_TICKS = xcvr_regs_pkg::FLUSH_TICKS
) (
    input wire logic clock_in,
    input wire logic rst_in,
    input wire logic [5:0] addr_in,
    input wire logic wr_en_in,
    input wire logic [7:0] wr_data_in,
    input wire logic rd_en_in,
    input wire xcvr_regs_pkg::status_s live_status_in,
    input wire logic oscillator_lock_detect_enable_in,
    input wire logic tx_pclk_tick_in,
    output logic [7:0] rd_data_out,
    output xcvr_regs_pkg::config_s config_out,
    output logic fifo_reset_out,
    output logic [4:0] change_out
);

    // ==========================================================
    // Parameter check
    // ==========================================================
    // A drain longer than the flush window would hold the FIFO in reset too long.
    if (FLUSH_TICKS < 1 || FLUSH_TICKS > xcvr_regs_pkg::FLUSH_MAX_TICKS)
    begin : g_bad_ticks
        $error("FLUSH_TICKS out of range");
    end

    // ==========================================================
    // Configuration field decode
    // ==========================================================
    // One decode serves reset and run, so the output never disagrees with the register.
    function automatic xcvr_regs_pkg::config_s cfg_fields(input logic [7:0] value);
        cfg_fields = '{
            ref_freq_select: value[xcvr_regs_pkg::BIT_REF_FREQ],
            multiplier_bandwidth_select: value[xcvr_regs_pkg::BIT_BANDWIDTH],
            dejitter_ref_select: value[xcvr_regs_pkg::BIT_DEJITTER],
            aux_clock_disable: value[xcvr_regs_pkg::BIT_AUX_DIS],
            auto_flush_enable: value[xcvr_regs_pkg::BIT_AUTO_FLUSH],
            manual_flush_bit: value[xcvr_regs_pkg::BIT_MANUAL_FLUSH]
        };
    endfunction

    // ==========================================================
    // Status synchronisation
    // ==========================================================
    logic [4:0] live_sync;
    xcvr_regs_pkg::status_s status_sync;

    // Two flops cost two cycles of latency but keep a metastable loop level off the read path.
    level_sync #(
        .WIDTH(xcvr_regs_pkg::STATUS_W)
    ) u_sync (
        .clock_in(clock_in),
        .rst_in(rst_in),
        .async_in(live_status_in),
        .sync_out(live_sync)
    );

    always_comb
    begin
        status_sync = live_sync;
        // Without the detector the lock input is meaningless, so it reads low.
        status_sync.oscillator_lock_flag = status_sync.oscillator_lock_flag
                                           & oscillator_lock_detect_enable_in;
    end

    // ==========================================================
    // Register file
    // ==========================================================
    logic [7:0] config_r;
    logic [7:0] config_nxt;
    logic [4:0] prev_r;
    logic [4:0] prev_nxt;
    logic [4:0] change_r;
    logic [4:0] change_nxt;
    logic [7:0] rd_data_nxt;
    logic [4:0] edges;
    xcvr_regs_pkg::config_s config_out_nxt;

    always_comb
    begin
        config_nxt = config_r;
        if (wr_en_in && addr_in == xcvr_regs_pkg::ADDR_CONFIG)
        begin
            config_nxt = wr_data_in;
        end
        config_out_nxt = cfg_fields(config_nxt);
        prev_nxt = status_sync;
        edges = status_sync ^ prev_r;
        change_nxt = change_r;
        if (rd_en_in && addr_in == xcvr_regs_pkg::ADDR_CHANGE)
        begin
            change_nxt = 5'h00;
        end
        // A change seen in the clearing cycle survives the clear.
        change_nxt = change_nxt | edges;
        rd_data_nxt = xcvr_regs_pkg::READ_ZERO;
        if (rd_en_in)
        begin
            unique case (addr_in)
                xcvr_regs_pkg::ADDR_CHANGE: rd_data_nxt = {3'h0, change_r};
                xcvr_regs_pkg::ADDR_STATUS: rd_data_nxt = {3'h0, status_sync};
                xcvr_regs_pkg::ADDR_CONFIG: rd_data_nxt = config_r;
                default: rd_data_nxt = xcvr_regs_pkg::READ_ZERO;
            endcase
        end
    end

    always_ff @(posedge clock_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            config_r <= xcvr_regs_pkg::CONFIG_RESET;
            prev_r <= 5'h00;
            change_r <= 5'h00;
            rd_data_out <= 8'h00;
        end
        else
        begin
            config_r <= config_nxt;
            prev_r <= prev_nxt;
            change_r <= change_nxt;
            rd_data_out <= rd_data_nxt;
        end
    end

    // ==========================================================
    // Transmit FIFO flush control
    // ==========================================================
    xcvr_regs_pkg::flush_state_e state_r;
    xcvr_regs_pkg::flush_state_e state_nxt;
    logic [3:0] ticks_r;
    logic [3:0] ticks_nxt;
    logic fifo_reset_nxt;
    logic overflow_rise;

    assign overflow_rise = edges[0] & status_sync.overflow_flag;

    always_comb
    begin
        state_nxt = state_r;
        ticks_nxt = ticks_r;
        // Manual hold has priority; a release then drains before normal use.
        if (config_nxt[xcvr_regs_pkg::BIT_MANUAL_FLUSH])
        begin
            state_nxt = xcvr_regs_pkg::FLUSH_HOLD;
            ticks_nxt = 4'h0;
        end
        else
        begin
            unique case (state_r)
                xcvr_regs_pkg::FLUSH_IDLE:
                begin
                    if (overflow_rise && config_r[xcvr_regs_pkg::BIT_AUTO_FLUSH])
                    begin
                        state_nxt = xcvr_regs_pkg::FLUSH_DRAIN;
                        ticks_nxt = 4'h0;
                    end
                end
                xcvr_regs_pkg::FLUSH_HOLD:
                begin
                    state_nxt = xcvr_regs_pkg::FLUSH_DRAIN;
                    ticks_nxt = 4'h0;
                end
                xcvr_regs_pkg::FLUSH_DRAIN:
                begin
                    if (tx_pclk_tick_in)
                    begin
                        ticks_nxt = ticks_r + 4'h1;
                        if (ticks_nxt == 4'(FLUSH_TICKS))
                        begin
                            state_nxt = xcvr_regs_pkg::FLUSH_IDLE;
                        end
                    end
                end
                // The unused fourth code falls back to idle rather than locking up.
                default: state_nxt = xcvr_regs_pkg::FLUSH_IDLE;
            endcase
        end
        fifo_reset_nxt = (state_nxt != xcvr_regs_pkg::FLUSH_IDLE);
    end

    always_ff @(posedge clock_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            state_r <= xcvr_regs_pkg::FLUSH_IDLE;
            ticks_r <= 4'h0;
            fifo_reset_out <= 1'b0;
            config_out <= cfg_fields(xcvr_regs_pkg::CONFIG_RESET);
            change_out <= 5'h00;
        end
        else
        begin
            state_r <= state_nxt;
            ticks_r <= ticks_nxt;
            fifo_reset_out <= fifo_reset_nxt;
            config_out <= config_out_nxt;
            change_out <= change_nxt;
        end
    end

endmodule

// ---- sim/xcvr_regs_props.sv ----
`timescale 1ns/1ps

module xcvr_props #(
    parameter int FLUSH_TICKS = 8
) (
    input wire logic clock_in,
    input wire logic rst_in,
    input wire logic [5:0] addr_in,
    input wire logic wr_en_in,
    input wire logic [7:0] wr_data_in,
    input wire logic rd_en_in,
    input wire xcvr_regs_pkg::status_s live_status_in,
    input wire logic oscillator_lock_detect_enable_in,
    input wire logic tx_pclk_tick_in,
    input wire logic [7:0] rd_data_out,
    input wire xcvr_regs_pkg::config_s config_out,
    input wire logic fifo_reset_out,
    input wire logic [4:0] change_out
);
    // ==========================================================
    // Drain tick counter
    // ==========================================================
    // Counts ticks while draining so a wrong count shows at the falling edge.
    logic [4:0] ticks_r;
    logic [4:0] ticks_nxt;
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (rst_in);
    always_comb
    begin
        ticks_nxt = 5'h00;
        if (fifo_reset_out && !config_out.manual_flush_bit)
            ticks_nxt = ticks_r + 5'(tx_pclk_tick_in);
    end
    always_ff @(posedge clock_in or posedge rst_in)
    begin
        if (rst_in)
            ticks_r <= 5'h00;
        else
            ticks_r <= ticks_nxt;
    end
    a_idle_read_zero: assert property (!rd_en_in |=> rd_data_out == 8'h00)
        else $error("read data not zero without read");
    a_unmapped_read: assert property (rd_en_in
        && !(addr_in inside {6'h01, 6'h02, 6'h03}) |=> rd_data_out == 8'h00)
        else $error("unmapped read not zero");
    a_status_upper: assert property (rd_en_in && addr_in == 6'h02
        |=> rd_data_out[7:5] == 3'h0) else $error("status upper bits set");
    a_status_value: assert property (($stable(live_status_in)
        && oscillator_lock_detect_enable_in)[*3] ##0 (rd_en_in && addr_in == 6'h02)
        |=> rd_data_out[4:0] == $past(live_status_in)) else $error("status value wrong");
    a_osc_masked: assert property ((!oscillator_lock_detect_enable_in)[*3] ##0
        (rd_en_in && addr_in == 6'h02) |=> !rd_data_out[4]) else $error("lock bit unmasked");
    a_config_write: assert property (wr_en_in
        && addr_in == 6'h03 |=> config_out == {$past(wr_data_in[6]), $past(wr_data_in[4:0])})
        else $error("config not written");
    a_config_keep: assert property (!(wr_en_in && addr_in == 6'h03)
        |=> $stable(config_out)) else $error("config changed without write");
    a_manual_hold: assert property (config_out.manual_flush_bit |-> fifo_reset_out)
        else $error("fifo not held in reset");
    a_drain_high: assert property ($fell(config_out.manual_flush_bit) |-> fifo_reset_out)
        else $error("drain ended at release");
    a_flush_count: assert property ($fell(fifo_reset_out) |->
        ticks_r >= FLUSH_TICKS - 1 && ticks_r <= FLUSH_TICKS + 1)
        else $error("drain length wrong");
    a_change_read: assert property (rd_en_in && addr_in == 6'h01
        |=> rd_data_out == {3'h0, $past(change_out)}) else $error("change latch read wrong");
endmodule

bind transceiver_status_config_regs xcvr_props #(.FLUSH_TICKS(FLUSH_TICKS)) u_props (
    .clock_in, .rst_in, .addr_in, .wr_en_in, .wr_data_in, .rd_en_in, .live_status_in,
    .oscillator_lock_detect_enable_in, .tx_pclk_tick_in, .rd_data_out, .config_out,
    .fifo_reset_out, .change_out);

// ---- sim/tb_top.sv ----
`timescale 1ns/1ps

module tb_top;
    logic clock_in = 1'b0;
    logic rst_in = 1'b1;
    logic [5:0] addr_in = 6'h00;
    logic wr_en_in = 1'b0;
    logic [7:0] wr_data_in = 8'h00;
    logic rd_en_in = 1'b0;
    xcvr_regs_pkg::status_s live_status_in = '0;
    logic oscillator_lock_detect_enable_in = 1'b0;
    logic tx_pclk_tick_in = 1'b0;
    logic [7:0] rd_data_out;
    xcvr_regs_pkg::config_s config_out;
    logic fifo_reset_out;
    logic [4:0] change_out;
    logic [7:0] exp_q[$];
    logic pend = 1'b0;
    logic [31:0] seed = 32'h000052E4;
    logic [7:0] d;
    int error_cnt = 0;
    int n_tests = 0;
    always #20 clock_in = ~clock_in;
    always @(posedge clock_in) #1 tx_pclk_tick_in = ~tx_pclk_tick_in;
    transceiver_status_config_regs DUT (.clock_in, .rst_in, .addr_in, .wr_en_in, .wr_data_in,
        .rd_en_in, .live_status_in, .oscillator_lock_detect_enable_in, .tx_pclk_tick_in,
        .rd_data_out, .config_out, .fifo_reset_out, .change_out);
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic chk(string n, logic [7:0] s, logic [7:0] e);
        n_tests++;
        if (s !== e)
        begin
            error_cnt++;
            $display("FAIL %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic cyc(int n);
        repeat (n) @(posedge clock_in);
        #1;
    endtask
    task automatic wr(logic [5:0] a, logic [7:0] v);
        addr_in = a;
        wr_data_in = v;
        wr_en_in = 1'b1;
        cyc(1);
        wr_en_in = 1'b0;
        // One idle edge keeps a following call from raising the strobe in the same step.
        cyc(1);
    endtask
    task automatic rd(logic [5:0] a, logic [7:0] e);
        addr_in = a;
        rd_en_in = 1'b1;
        exp_q.push_back(e);
        cyc(1);
        rd_en_in = 1'b0;
        cyc(1);
    endtask
    task automatic wait_low();
        for (int i = 0; i < 60 && fifo_reset_out !== 1'b0; i++)
            cyc(1);
        chk("fifo_reset_out", 8'(fifo_reset_out), 8'h00);
        if (fifo_reset_out !== 1'b0)
            tally_and_finish();
    endtask
    // ==========================================================
    // Read monitor
    // ==========================================================
    always @(posedge clock_in)
    begin
        if (pend)
            chk("rd_data_out", rd_data_out, exp_q.pop_front());
        pend <= rd_en_in;
    end
    initial
    begin
        cyc(8);
        rst_in = 1'b0;
        rd(6'h03, 8'h40);
        rd(6'h02, 8'h00);
        rd(6'h01, 8'h00);
        rd(6'h05, 8'h00);
        chk("config_out", 8'(config_out), 8'h20);
        // Reserved bits and bit 0 stay low here; the flush logic is exercised only below.
        repeat (8)
        begin
            d = 8'(rnd()) & 8'h5E;
            wr(6'h03, d);
            wr(6'h02, ~d);
            rd(6'h03, d);
            chk("config_out", 8'(config_out), {2'h0, d[6], d[4:0]});
        end
        wr(6'h03, 8'h40);
        live_status_in = 5'h1F;
        cyc(4);
        chk("change_out", 8'(change_out), 8'h0F);
        rd(6'h01, 8'h0F);
        rd(6'h01, 8'h00);
        chk("change_out", 8'(change_out), 8'h00);
        repeat (12)
        begin
            d = 8'(rnd());
            live_status_in = d[4:0];
            oscillator_lock_detect_enable_in = d[7];
            cyc(3);
            rd(6'h02, {3'h0, d[4] & d[7], d[3:0]});
        end
        live_status_in = 5'h00;
        wr(6'h03, 8'h41);
        chk("fifo_reset_out", 8'(fifo_reset_out), 8'h01);
        cyc(4);
        wr(6'h03, 8'h40);
        chk("fifo_reset_out", 8'(fifo_reset_out), 8'h01);
        wait_low();
        live_status_in = 5'h01;
        cyc(5);
        chk("fifo_reset_out", 8'(fifo_reset_out), 8'h00);
        live_status_in = 5'h00;
        wr(6'h03, 8'h42);
        cyc(3);
        live_status_in = 5'h01;
        cyc(5);
        chk("fifo_reset_out", 8'(fifo_reset_out), 8'h01);
        wait_low();
        cyc(2);
        // A second reset must restore the defaults after flush and status activity.
        live_status_in = 5'h00;
        rst_in = 1'b1;
        cyc(2);
        chk("config_out", 8'(config_out), 8'h20);
        chk("fifo_reset_out", 8'(fifo_reset_out), 8'h00);
        chk("change_out", 8'(change_out), 8'h00);
        rst_in = 1'b0;
        rd(6'h03, 8'h40);
        rd(6'h02, 8'h00);
        rd(6'h01, 8'h00);
        cyc(2);
        tally_and_finish();
    end
endmodule
